// ==== scl_sync.sv ====
`timescale 1ns/100ps
package scl_pkg;
  // Register byte addresses on the Wishbone slave
  localparam int          ADR_W          = 8;
  localparam logic [7:0]  ADR_CTRL       = 8'h00;
  localparam logic [7:0]  ADR_CFG        = 8'h04;
  localparam logic [7:0]  ADR_BASE       = 8'h08;
  localparam logic [7:0]  ADR_SA0        = 8'h0c;
  localparam logic [7:0]  ADR_SA1        = 8'h10;
  localparam logic [7:0]  ADR_SA2        = 8'h14;
  localparam logic [7:0]  ADR_PTR        = 8'h18;
  localparam logic [7:0]  ADR_GP         = 8'h1c;
  // Control register fields
  localparam int          CTRL_SEL_BIT   = 0;
  localparam int          CTRL_RLD_BIT   = 1;
  localparam int          CTRL_STO_BIT   = 2;
  localparam int          CTRL_LOW_BITS  = 3;
  // EEPROM organisation and command set
  localparam int          EE_AW          = 6;
  localparam int          EE_DW          = 16;
  localparam logic [5:0]  SA_ADDR0       = 6'h20;
  localparam logic [2:0]  STRAP_FIXED    = 3'h7;
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [1:0]  OP_WRITE       = 2'h1;
  localparam logic [1:0]  OP_EWEN        = 2'h0;
  localparam logic [5:0]  EWEN_ADDR      = 6'h30;
  localparam logic [1:0]  OFS_CFG        = 2'h0;
  localparam logic [1:0]  OFS_BASE       = 2'h1;
  localparam int          CMD_BITS       = 9;
  localparam int          FRAME_BITS     = 25;
  // Reset values
  localparam logic [15:0] BASE_DEFAULT   = 16'h0300;
  localparam logic [15:0] CFG_DEFAULT    = 16'h0000;
  localparam logic [15:0] SA_DEFAULT     = 16'h0000;
  // Timing: serial clock half period is a least time, so it rounds up
  localparam int          CLK_MHZ        = 250;
  localparam int          SK_HALF_NS     = 500;
  localparam int          SK_HALF_CYC    = (SK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int          WR_TIMEOUT_US  = 10000;
  localparam int          BOOT_WAIT_CYC  = 8;

  typedef enum logic [1:0] {JOB_LOAD, JOB_STORE, JOB_GPRD, JOB_GPWR} scl_job_e;
  typedef enum logic [2:0] {DST_CFG, DST_BASE, DST_SA0, DST_SA1, DST_SA2, DST_GP} scl_dst_e;
  typedef enum logic [2:0] {S_BOOT, S_IDLE, S_FETCH, S_LO, S_HI, S_GAP, S_RDY, S_END} scl_st_e;

  // Registers that the loader fills and, apart from the station address, stores
  typedef struct packed {
    logic [15:0]      cfg;
    logic [15:0]      base;
    logic [2:0][15:0] sa;
  } scl_regs_s;

  // One serial word operation
  typedef struct packed {
    logic        en;
    logic        fin;
    logic        wr;
    logic [1:0]  opc;
    logic [5:0]  addr;
    logic [15:0] data;
    scl_dst_e    dst;
    logic [4:0]  nclk;
  } scl_op_s;
endpackage : scl_pkg

module scl_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,  // Core clock
  input  wire logic         rst_i,  // Synchronous reset
  input  wire logic         ce_i,   // Clock enable
  input  wire logic [W-1:0] d_i,    // Asynchronous pin level
  output logic      [W-1:0] q_o     // Filtered level
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [W-1:0] s1_d, s2_d, s3_d, lvl_d;

  // Level moves only where the second and third stages agree
  always_comb begin
    s1_d  = d_i;
    s2_d  = s1_q;
    s3_d  = s2_q;
    lvl_d = lvl_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else if (ce_i) begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  assign q_o = lvl_q;
endmodule : scl_sync3

// ==== scl_loader.sv ====
// Function
// - After reset the loader fetches station address, base and configuration from EEPROM.
// - Configuration word sits at four times the strap value, base word just after.
// - Station address words live at 20h, 21h and 22h whatever the straps say.
// - Strap value 7 loads only the station address, others keep defaults.
// - Strap value 7 keeps the fixed default base, ignoring the EEPROM value.
// - Software sets reload or store to start, then polls until it reads low.
// - Control reads show reload and store both high while a transfer runs.
// - Other register accesses wait until the transfer is over.
// - Busy and lockout also cover the load that follows reset.
// - EEPROM is 64 words of 16 bits, moved whole, by word address.
// - Normal reload fills configuration, base and station address registers.
// - Normal store writes configuration and base to the strap-selected words.
// - The three low control bits never go to or come from the EEPROM.
// - General mode reload copies the word at pointer bits 5:0 into the GP register.
// - General mode store writes the GP register to the word at pointer bits 5:0.
// - With the present strap low there is no EEPROM traffic, registers keep defaults.
// - Without EEPROM the base is 300h and station address is zero.
`timescale 1ns/100ps
module scl_loader
  import scl_pkg::*;
#(
  parameter logic [15:0] CFG_RST        = CFG_DEFAULT,
  parameter int          WR_TIMEOUT_CYC = WR_TIMEOUT_US * CLK_MHZ
) (
  input  wire logic        clk_i,                   // Core clock, 250 MHz
  input  wire logic        rst_i,                   // Synchronous reset, active high
  input  wire logic        ce_i,                    // Clock enable, freezes all state
  input  wire logic        wb_cyc_i,                // Wishbone cycle
  input  wire logic        wb_stb_i,                // Wishbone strobe
  input  wire logic        wb_we_i,                 // Wishbone write
  input  wire logic [7:0]  wb_adr_i,                // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,                // Wishbone byte enables
  input  wire logic [31:0] wb_dat_i,                // Wishbone write data
  output logic      [31:0] wb_dat_o,                // Wishbone read data
  output logic             wb_ack_o,                // Wishbone acknowledge
  input  wire logic [2:0]  eeprom_offset_straps_i,  // Word offset straps
  input  wire logic        eeprom_present_strap_i,  // High when an EEPROM is fitted
  input  wire logic        ee_do_i,                 // Serial data from EEPROM
  output logic             ee_cs_o,                 // EEPROM chip select
  output logic             ee_sk_o,                 // EEPROM serial clock
  output logic             ee_di_o,                 // Serial data to EEPROM
  output scl_regs_s        regs_o,                  // Loaded register contents
  output logic             busy_o                   // Transfer in progress
);
  localparam int TMR_W = $clog2(WR_TIMEOUT_CYC + 1);
  localparam int DIV_W = $clog2(SK_HALF_CYC + 1);
  localparam logic [TMR_W-1:0] TMR_MAX  = TMR_W'(WR_TIMEOUT_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SK_HALF_CYC - 1);
  localparam logic [4:0]       CMD_N    = 5'(CMD_BITS);
  localparam logic [4:0]       FRAME_N  = 5'(FRAME_BITS);
  localparam logic [3:0]       BOOT_N   = 4'(BOOT_WAIT_CYC);

  logic [2:0] strap_lvl;
  logic       present_lvl;
  logic       do_lvl;

  // Pins come from outside the clock domain
  scl_sync3 #(.W(5)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   ({eeprom_present_strap_i, ee_do_i, eeprom_offset_straps_i}),
    .q_o   ({present_lvl, do_lvl, strap_lvl})
  );

  scl_st_e            st_q, st_d;
  scl_job_e           job_q, job_d;
  scl_op_s            op_q, op_d;
  scl_regs_s          regs_q, regs_d;
  logic [2:0]         step_q, step_d;
  logic [4:0]         bit_q, bit_d;
  logic [24:0]        sh_q, sh_d;
  logic [15:0]        rx_q, rx_d;
  logic [DIV_W-1:0]   div_q, div_d;
  logic [TMR_W-1:0]   tmr_q, tmr_d;
  logic [3:0]         boot_q, boot_d;
  logic [2:0]         strap_q, strap_d;
  logic               present_q, present_d;
  logic               sel_q, sel_d;
  logic [15:CTRL_LOW_BITS] chi_q, chi_d;
  logic [EE_AW-1:0]   ptr_q, ptr_d;
  logic [15:CTRL_LOW_BITS-3+EE_AW] ptr_hi_q, ptr_hi_d;
  logic [15:0]        gp_q, gp_d;
  logic               busy_q, busy_d;
  logic               cs_q, cs_d, sk_q, sk_d, di_q, di_d;
  logic               ack_q, ack_d;
  logic [31:0]        dat_q, dat_d;
  logic               req, allow;
  scl_op_s            op_c;

  // Word operation for a given step of the current job
  function automatic scl_op_s step_op(input scl_job_e j, input logic [2:0] s,
                                      input logic [2:0] strap, input scl_regs_s r,
                                      input logic [5:0] ptr, input logic [15:0] gp);
    scl_op_s o;
    o = '{en: 1'b0, fin: 1'b0, wr: 1'b0, opc: OP_READ, addr: '0, data: '0,
          dst: DST_GP, nclk: FRAME_N};
    unique case (j)
      JOB_LOAD: begin
        if (s < 3'd2) begin
          o.en   = (strap != STRAP_FIXED);
          o.addr = {1'b0, strap, (s == 3'd0) ? OFS_CFG : OFS_BASE};
          o.dst  = (s == 3'd0) ? DST_CFG : DST_BASE;
        end else if (s < 3'd5) begin
          o.en   = 1'b1;
          o.addr = SA_ADDR0 + 6'(s - 3'd2);
          o.dst  = scl_dst_e'(3'(DST_SA0) + s - 3'd2);
        end else begin
          o.fin  = 1'b1;
        end
      end
      JOB_STORE: begin
        // No strap-selected words exist for the fixed setting
        o.en = (strap != STRAP_FIXED);
        if (s == 3'd0) begin
          o.opc  = OP_EWEN;
          o.addr = EWEN_ADDR;
          o.nclk = CMD_N;
        end else if (s < 3'd3) begin
          o.wr   = 1'b1;
          o.opc  = OP_WRITE;
          o.addr = {1'b0, strap, (s == 3'd1) ? OFS_CFG : OFS_BASE};
          o.data = (s == 3'd1) ? r.cfg : r.base;
        end else begin
          o.fin  = 1'b1;
        end
      end
      JOB_GPRD: begin
        o.en   = (s == 3'd0);
        o.fin  = (s != 3'd0);
        o.addr = ptr;
      end
      JOB_GPWR: begin
        o.en   = (s < 3'd2);
        o.fin  = (s >= 3'd2);
        o.opc  = (s == 3'd0) ? OP_EWEN : OP_WRITE;
        o.addr = (s == 3'd0) ? EWEN_ADDR : ptr;
        o.nclk = (s == 3'd0) ? CMD_N : FRAME_N;
        o.wr   = (s != 3'd0);
        o.data = gp;
      end
    endcase
    return o;
  endfunction : step_op

  // Bus request decode; a busy loader holds every access except control
  assign req   = wb_cyc_i && wb_stb_i && !ack_q;
  assign allow = !busy_q || (wb_adr_i == ADR_CTRL);
  assign op_c  = step_op(job_q, step_q, strap_q, regs_q, ptr_q, gp_q);

  // Next state of bus slave, register file and serial sequencer
  always_comb begin
    st_d = st_q; job_d = job_q; op_d = op_q; regs_d = regs_q; step_d = step_q;
    bit_d = bit_q; sh_d = sh_q; rx_d = rx_q; div_d = div_q; tmr_d = tmr_q;
    boot_d = boot_q; strap_d = strap_q; present_d = present_q; sel_d = sel_q;
    chi_d = chi_q; ptr_d = ptr_q; ptr_hi_d = ptr_hi_q; gp_d = gp_q; busy_d = busy_q;
    cs_d = cs_q; sk_d = sk_q; di_d = di_q; ack_d = 1'b0; dat_d = dat_q;

    if (req && allow) begin
      ack_d = 1'b1;
      dat_d = '0;
      unique case (wb_adr_i)
        ADR_CTRL: dat_d[15:0] = {chi_q, busy_q, busy_q, sel_q};
        ADR_CFG:  dat_d[15:0] = regs_q.cfg;
        ADR_BASE: dat_d[15:0] = regs_q.base;
        ADR_SA0:  dat_d[15:0] = regs_q.sa[0];
        ADR_SA1:  dat_d[15:0] = regs_q.sa[1];
        ADR_SA2:  dat_d[15:0] = regs_q.sa[2];
        ADR_PTR:  dat_d[15:0] = {ptr_hi_q, ptr_q};
        ADR_GP:   dat_d[15:0] = gp_q;
        default:  dat_d       = '0;
      endcase
      // Writes to control during a transfer are dropped, polling still answers
      if (wb_we_i && !busy_q) begin
        unique case (wb_adr_i)
          ADR_CTRL: begin
            if (wb_sel_i[0]) begin
              sel_d         = wb_dat_i[CTRL_SEL_BIT];
              chi_d[7:3]    = wb_dat_i[7:3];
              strap_d       = strap_lvl;
              step_d        = '0;
              // Reload wins over store; nothing starts without an EEPROM
              if (present_q && (wb_dat_i[CTRL_RLD_BIT] || wb_dat_i[CTRL_STO_BIT])) begin
                busy_d = 1'b1;
                st_d   = S_FETCH;
                if (wb_dat_i[CTRL_RLD_BIT]) begin
                  job_d = wb_dat_i[CTRL_SEL_BIT] ? JOB_GPRD : JOB_LOAD;
                end else begin
                  job_d = wb_dat_i[CTRL_SEL_BIT] ? JOB_GPWR : JOB_STORE;
                end
              end
            end
            if (wb_sel_i[1]) chi_d[15:8] = wb_dat_i[15:8];
          end
          ADR_CFG: begin
            if (wb_sel_i[0]) regs_d.cfg[7:0]  = wb_dat_i[7:0];
            if (wb_sel_i[1]) regs_d.cfg[15:8] = wb_dat_i[15:8];
          end
          ADR_BASE: begin
            if (wb_sel_i[0]) regs_d.base[7:0]  = wb_dat_i[7:0];
            if (wb_sel_i[1]) regs_d.base[15:8] = wb_dat_i[15:8];
          end
          ADR_SA0, ADR_SA1, ADR_SA2: begin
            if (wb_sel_i[0]) regs_d.sa[wb_adr_i[4:2] - 3'd3][7:0]  = wb_dat_i[7:0];
            if (wb_sel_i[1]) regs_d.sa[wb_adr_i[4:2] - 3'd3][15:8] = wb_dat_i[15:8];
          end
          ADR_PTR: begin
            if (wb_sel_i[0]) {ptr_hi_d[7:6], ptr_d} = wb_dat_i[7:0];
            if (wb_sel_i[1]) ptr_hi_d[15:8] = wb_dat_i[15:8];
          end
          ADR_GP: begin
            if (wb_sel_i[0]) gp_d[7:0]  = wb_dat_i[7:0];
            if (wb_sel_i[1]) gp_d[15:8] = wb_dat_i[15:8];
          end
          default: ;
        endcase
      end
    end

    // Serial sequencer; the half-period divider paces the clock, gap and end phases, the ready wait runs on its own timer
    unique case (st_q)
      S_BOOT: begin
        // Let the strap synchronisers settle before sampling them
        boot_d = boot_q + 4'd1;
        if (boot_q == BOOT_N) begin
          present_d = present_lvl;
          strap_d   = strap_lvl;
          job_d     = JOB_LOAD;
          step_d    = '0;
          busy_d    = present_lvl;
          st_d      = present_lvl ? S_FETCH : S_IDLE;
        end
      end
      S_IDLE: ;
      S_FETCH: begin
        op_d  = op_c;
        div_d = '0;
        bit_d = '0;
        if (op_c.fin) begin
          busy_d = 1'b0;
          st_d   = S_IDLE;
        end else if (!op_c.en) begin
          step_d = step_q + 3'd1;
        end else begin
          sh_d = {1'b1, op_c.opc, op_c.addr, op_c.data};
          cs_d = 1'b1;
          sk_d = 1'b0;
          di_d = 1'b1;
          st_d = S_LO;
        end
      end
      S_LO: begin
        div_d = div_q + DIV_W'(1);
        if (div_q == DIV_LAST) begin
          div_d = '0;
          sk_d  = 1'b1;
          st_d  = S_HI;
        end
      end
      S_HI: begin
        div_d = div_q + DIV_W'(1);
        if (div_q == DIV_LAST) begin
          div_d = '0;
          if (op_q.opc == OP_READ && bit_q >= CMD_N) begin
            rx_d = {rx_q[14:0], do_lvl};
          end
          sh_d  = {sh_q[23:0], 1'b0};
          bit_d = bit_q + 5'd1;
          sk_d  = 1'b0;
          // Receive phase drives a steady low on the data line
          di_d  = (op_q.opc == OP_READ && bit_q + 5'd1 >= CMD_N) ? 1'b0 : sh_q[23];
          if (bit_q + 5'd1 == op_q.nclk) begin
            cs_d = 1'b0;
            di_d = 1'b0;
            st_d = S_GAP;
          end else begin
            st_d = S_LO;
          end
        end
      end
      S_GAP: begin
        div_d = div_q + DIV_W'(1);
        if (div_q == DIV_LAST) begin
          div_d = '0;
          tmr_d = '0;
          if (op_q.wr) begin
            cs_d = 1'b1;
            st_d = S_RDY;
          end else begin
            if (op_q.opc == OP_READ) begin
              unique case (op_q.dst)
                DST_CFG:  regs_d.cfg   = rx_q;
                DST_BASE: regs_d.base  = rx_q;
                DST_SA0:  regs_d.sa[0] = rx_q;
                DST_SA1:  regs_d.sa[1] = rx_q;
                DST_SA2:  regs_d.sa[2] = rx_q;
                DST_GP:   gp_d         = rx_q;
                default: ;
              endcase
            end
            step_d = step_q + 3'd1;
            st_d   = S_FETCH;
          end
        end
      end
      S_RDY: begin
        // A timeout keeps a missing or dead memory from locking the bus forever
        tmr_d = tmr_q + TMR_W'(1);
        if ((tmr_q > TMR_W'(SK_HALF_CYC) && do_lvl) || tmr_q == TMR_MAX) begin
          cs_d = 1'b0;
          st_d = S_END;
        end
      end
      S_END: begin
        div_d = div_q + DIV_W'(1);
        if (div_q == DIV_LAST) begin
          div_d  = '0;
          step_d = step_q + 3'd1;
          st_d   = S_FETCH;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= S_BOOT; job_q <= JOB_LOAD; op_q <= '0; step_q <= '0; bit_q <= '0;
      sh_q <= '0; rx_q <= '0; div_q <= '0; tmr_q <= '0; boot_q <= '0;
      strap_q <= '0; present_q <= 1'b0; sel_q <= 1'b0; chi_q <= '0;
      regs_q <= '{cfg: CFG_RST, base: BASE_DEFAULT, sa: {3{SA_DEFAULT}}};
      ptr_q <= '0; ptr_hi_q <= '0; gp_q <= '0;
      busy_q <= 1'b1;
      cs_q <= 1'b0; sk_q <= 1'b0; di_q <= 1'b0; ack_q <= 1'b0; dat_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d; job_q <= job_d; op_q <= op_d; step_q <= step_d; bit_q <= bit_d;
      sh_q <= sh_d; rx_q <= rx_d; div_q <= div_d; tmr_q <= tmr_d; boot_q <= boot_d;
      strap_q <= strap_d; present_q <= present_d; sel_q <= sel_d; chi_q <= chi_d;
      regs_q <= regs_d; ptr_q <= ptr_d; ptr_hi_q <= ptr_hi_d; gp_q <= gp_d;
      busy_q <= busy_d;
      cs_q <= cs_d; sk_q <= sk_d; di_q <= di_d; ack_q <= ack_d; dat_q <= dat_d;
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign ee_cs_o  = cs_q;
  assign ee_sk_o  = sk_q;
  assign ee_di_o  = di_q;
  assign regs_o   = regs_q;
  assign busy_o   = busy_q;

  // Checks on the bus slave and the serial sequencer
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_frame_start;
    (st_q == S_FETCH) && op_c.en && !op_c.fin && ce_i;
  endsequence

  a_ack_pulse_only: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");
  a_ctrl_busy_read: assert property (req && allow && !wb_we_i && wb_adr_i == ADR_CTRL
      && busy_q && ce_i |=> wb_ack_o && wb_dat_o[2:1] == 2'b11)
    else $error("busy control read did not show both bits high");
  a_lockout_held: assert property (busy_q && req && wb_adr_i != ADR_CTRL |=> !wb_ack_o)
    else $error("access answered during a transfer");
  a_boot_busy: assert property ($fell(rst_i) |-> busy_o && st_q == S_BOOT)
    else $error("reset load not marked busy");
  a_absent_quiet: assert property (st_q != S_BOOT && !present_q |-> !ee_cs_o && !busy_o)
    else $error("EEPROM touched while absent");
  a_start_bit_sent: assert property (s_frame_start |=> ee_cs_o && ee_di_o && !ee_sk_o)
    else $error("frame did not open with the start bit");
  a_sk_half_hold: assert property ($rose(ee_sk_o) |=> $stable(ee_sk_o)[*8])
    else $error("serial clock high phase too short");
  a_fixed_base: assert property (st_q == S_LO && op_q.dst == DST_BASE && op_q.opc == OP_READ
      |-> strap_q != STRAP_FIXED)
    else $error("base fetched with the fixed strap setting");
  a_write_ready: assert property (st_q == S_RDY && st_d == S_END && ce_i
      |-> do_lvl || tmr_q == TMR_MAX)
    else $error("write ended before the ready level");
endmodule : scl_loader

// ==== scl_eeprom_model.sv ====
`timescale 1ns/100ps
module scl_eeprom_model
  import scl_pkg::*;
#(
  parameter int BUSY_NS = 400  // Internal write time before ready shows
) (
  input  wire logic cs_i,  // Chip select
  input  wire logic sk_i,  // Serial clock
  input  wire logic di_i,  // Serial data in
  output logic      do_o   // Serial data out
);
  logic [15:0] mem [64];
  logic [24:0] sh;
  logic [5:0]  a;
  int          n;
  logic        wen, rdy, rd, q;
  // Known contents so every word can be predicted by the bench
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = {~{2'h0, 6'(i)}, 2'h0, 6'(i)};
    {wen, rdy, rd, q, n, sh, a} = '0;
    rdy = 1'b1;
  end
  // Each frame starts afresh on select
  always @(posedge cs_i) begin
    n = 0;
    rd = 1'b0;
  end
  // Shift on rising clock; read data follows a dummy zero
  always @(posedge sk_i) if (cs_i) begin
    sh = {sh[23:0], di_i};
    n++;
    if (n == 9 && sh[7:6] == OP_READ) begin
      rd = 1'b1;
      a = sh[5:0];
      q = 1'b0;
    end else if (rd && n > 9 && n < 26) q = mem[a][25-n];
  end
  // Commands act on deselect; writes need a prior enable
  always @(negedge cs_i) begin
    if (n == 9 && sh[7:6] == OP_EWEN) wen = (sh[5:4] == 2'h3);
    if (n == 25 && sh[23:22] == OP_WRITE && wen) begin
      mem[sh[21:16]] = sh[15:0];
      rdy = 1'b0;
      rdy <= #BUSY_NS 1'b1;
    end
  end
  // Released line shows the inverse of the last read bit; read data during a read, else ready level while selected
  assign do_o = !cs_i ? ~q : (rd ? q : rdy);
endmodule : scl_eeprom_model

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import scl_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pres = 1, lk;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic [2:0]  strap = 3'h2;
  logic        ack, cs, sk, di, do_w, busy;
  scl_regs_s   regs;
  int          n_fail = 0, checks_done = 0, n_cs = 0;

  scl_loader #(.WR_TIMEOUT_CYC(200)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .eeprom_offset_straps_i(strap),
    .eeprom_present_strap_i(pres), .ee_do_i(do_w), .ee_cs_o(cs), .ee_sk_o(sk),
    .ee_di_o(di), .regs_o(regs), .busy_o(busy));
  scl_eeprom_model MEM (.cs_i(cs), .sk_i(sk), .di_i(di), .do_o(do_w));

  // 250 MHz core clock
  initial forever #2 clk_i = ~clk_i;
  // Count frames, so a board without memory can be shown silent
  always @(posedge cs) n_cs++;

  function automatic logic [15:0] word(input logic [5:0] a);
    return {~{2'h0, a}, 2'h0, a};
  endfunction : word

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Classic cycle; busy is noted at the ack edge to see the lockout
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'h3, d};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 60000);
    q = rdat;
    lk = busy;
    {cyc, stb} <= 2'b00;
    if (t >= 60000) n_fail++;
  endtask : wb

  // Software waits for both start bits to clear
  task automatic poll();
    int k;
    k = 0;
    do begin
      wb(0, ADR_CTRL, 0);
      k++;
    end while (q[2:1] !== 2'b00 && k < 20000);
    // A poll that never sees both bits clear counts as a failure
    if (q[2:1] !== 2'b00) n_fail++;
  endtask : poll

  task automatic do_reset(input logic p, input logic [2:0] s);
    @(posedge clk_i);
    {rst_i, pres, strap} <= {1'b1, p, s};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    n_cs = 0;
  endtask : do_reset

  task automatic chk_load(input logic [15:0] c, input logic [15:0] b, input logic on);
    wb(0, ADR_CFG, 0);
    check(q, {16'h0, c});
    check({31'h0, lk}, 32'h0);
    check({regs.cfg, regs.base}, {c, b});
    wb(0, ADR_BASE, 0);
    check(q, {16'h0, b});
    for (int i = 0; i < 3; i++) begin
      wb(0, ADR_SA0 + 8'(4 * i), 0);
      check(q, on ? {16'h0, word(6'h20 + 6'(i))} : 32'h0);
    end
  endtask : chk_load

  task automatic finish_test();
    $display("Checks %0d, errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // Main sequence: reset load, general access, store, straps, no memory
  initial begin
    do_reset(1, 3'h2);
    wb(0, ADR_CTRL, 0);
    check({29'h0, q[2:0]}, 32'h6);
    chk_load(word(6'h08), word(6'h09), 1);
    wb(0, ADR_CTRL, 0);
    check(q, 32'h0);
    wb(1, 8'h40, 32'hffff);
    wb(0, 8'h40, 0);
    check(q, 32'h0);
    wb(1, ADR_PTR, 32'hffc5);
    wb(0, ADR_PTR, 0);
    check(q, 32'hffc5);
    wb(1, ADR_GP, 32'hbeef);
    wb(1, ADR_CTRL, 32'h5);
    poll();
    check({16'h0, MEM.mem[5]}, 32'hbeef);
    wb(1, ADR_PTR, 32'h21);
    wb(1, ADR_CTRL, 32'h3);
    poll();
    check(q, 32'h1);
    wb(0, ADR_GP, 0);
    check(q, {16'h0, word(6'h21)});
    wb(1, ADR_CFG, 32'h1234);
    wb(1, ADR_BASE, 32'h0320);
    wb(1, ADR_CTRL, 32'h4);
    poll();
    check({MEM.mem[8], MEM.mem[9]}, 32'h12340320);
    do_reset(1, 3'h7);
    chk_load(CFG_DEFAULT, BASE_DEFAULT, 1);
    do_reset(0, 3'h2);
    chk_load(CFG_DEFAULT, BASE_DEFAULT, 0);
    check(32'(n_cs), 32'h0);
    finish_test();
  end

  // Watchdog just above the expected run of about 82k cycles, inside the run budget
  initial begin
    repeat (99000) @(posedge clk_i);
    n_fail++;
    finish_test();
  end
endmodule : testbench
